// ---- inc/pdc_pkg.sv ----
`default_nettype none
package pdc_pkg;
	// --------------------------------------------------------------------
	// Structure
	// --------------------------------------------------------------------
	localparam int NUM_CHAN = 4;
	localparam int NUM_SYSREF = 8;
	localparam int CLK_DELAY_STEPS = 256;
	localparam int CLK_DELAY_W = 8;
	localparam int SYSREF_DELAY_W = 3;
	localparam int MULT_W = 2;
	localparam int DIV_W = 8;
	localparam int FINE_W = 5;
	localparam int DAC_W = 15;
	localparam int ACC_W = 16;
	localparam int TARGET_W = 10;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// --------------------------------------------------------------------
	// Register offsets (byte addresses)
	// --------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PREDIV = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FBDIV = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CLK_DELAY = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_SYSREF_DELAY = 8'h40;
	// --------------------------------------------------------------------
	// Fields and reset values
	// --------------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_MULT_LSB = 1;
	localparam int RESULT_VALID_BIT = 15;
	localparam int RESULT_BUSY_BIT = 16;
	localparam int RESULT_OSC_BIT = 17;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_LIMIT_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [DIV_W-1:0] PREDIV_RESET = 8'h01;
	localparam logic [DIV_W-1:0] FBDIV_RESET = 8'h01;
	localparam logic [MULT_W-1:0] MULT_RESET = 2'h0;
	localparam logic [DAC_W-1:0] DAC_MIN = 15'h0000;
	localparam logic [DAC_W-1:0] DAC_MAX = 15'h7FFF;
	localparam logic [SYSREF_DELAY_W-1:0] SYSREF_LEAD_MAX = 3'h3;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_WINDOW = 2'b01,
		CAL_DECIDE = 2'b11,
		CAL_DONE = 2'b10
	} pdc_cal_state_t;
endpackage
`default_nettype wire

// ---- design/pdc_delay_line.sv ----
`default_nettype none
module pdc_delay_line #(
	parameter int DEPTH = pdc_pkg::CLK_DELAY_STEPS,
	parameter int SEL_W = pdc_pkg::CLK_DELAY_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	input wire logic [SEL_W-1:0] sel,
	output logic dout_reg
);
	import pdc_pkg::*;
	logic [DEPTH-1:0] hist_reg;
	initial begin
		if (DEPTH != (1 << SEL_W)) begin
			$error("pdc_delay_line: DEPTH must equal 2**SEL_W");
		end
	end
	// History of the channel input; tap k is the input k+1 periods ago.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hist_reg <= '0;
			dout_reg <= 1'b0;
		end else begin
			hist_reg <= {hist_reg[DEPTH-2:0], din};
			dout_reg <= hist_reg[sel];
		end
	end
endmodule
`default_nettype wire

// ---- design/pdc_cal_engine.sv ----
`default_nettype none
module pdc_cal_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [pdc_pkg::DIV_W-1:0] prediv,
	input wire logic [pdc_pkg::DIV_W-1:0] fbdiv,
	input wire logic [pdc_pkg::MULT_W-1:0] mult,
	output logic busy,
	output logic done,
	output logic [pdc_pkg::DAC_W-1:0] code_reg
);
	import pdc_pkg::*;
	pdc_cal_state_t state_reg, state_next;
	logic [DAC_W-1:0] trial_reg;
	logic [3:0] bit_reg;
	logic [DIV_W-1:0] win_reg;
	logic [ACC_W-1:0] acc_reg;
	logic [TARGET_W-1:0] edges_reg;
	wire [ACC_W:0] acc_sum = {1'b0, acc_reg} + {2'b00, trial_reg};
	wire [TARGET_W-1:0] target = TARGET_W'(fbdiv) * TARGET_W'({1'b0, mult} + 3'h1);
	wire win_end = (win_reg >= prediv);
	wire too_fast = (edges_reg > target);
	wire [DAC_W-1:0] bit_mask = DAC_W'(1) << bit_reg;
	assign busy = (state_reg != CAL_IDLE);
	assign done = (state_reg == CAL_DONE);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CAL_IDLE: if (start) state_next = CAL_WINDOW;
			CAL_WINDOW: if (win_end) state_next = CAL_DECIDE;
			CAL_DECIDE: state_next = (bit_reg == 4'h0) ? CAL_DONE : CAL_WINDOW;
			CAL_DONE: state_next = CAL_IDLE;
			default: state_next = CAL_IDLE;
		endcase
	end
	// Successive approximation of the oscillator control word: the modelled
	// oscillator edge count over one reference period is held to the
	// feedback target, so the code settles where f1 equals f2.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= CAL_IDLE;
			trial_reg <= '0;
			bit_reg <= '0;
			win_reg <= '0;
			acc_reg <= '0;
			edges_reg <= '0;
			code_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_reg == CAL_IDLE && start) begin
				trial_reg <= DAC_W'(1) << (DAC_W - 1);
				bit_reg <= 4'(DAC_W - 1);
				win_reg <= DIV_W'(1);
				acc_reg <= '0;
				edges_reg <= '0;
			end else if (state_reg == CAL_WINDOW) begin
				acc_reg <= acc_sum[ACC_W-1:0];
				edges_reg <= edges_reg + TARGET_W'(acc_sum[ACC_W]);
				win_reg <= win_reg + DIV_W'(1);
			end else if (state_reg == CAL_DECIDE) begin
				win_reg <= DIV_W'(1);
				acc_reg <= '0;
				edges_reg <= '0;
				if (bit_reg != 4'h0) begin
					bit_reg <= bit_reg - 4'h1;
					trial_reg <= (too_fast ? (trial_reg & ~bit_mask) : trial_reg) | (bit_mask >> 1);
				end else begin
					code_reg <= too_fast ? (trial_reg & ~bit_mask) : trial_reg;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/pdc_top.sv ----
`default_nettype none
module pdc_top #(
	parameter int NUM_CHAN = pdc_pkg::NUM_CHAN,
	parameter int NUM_SYSREF = pdc_pkg::NUM_SYSREF,
	parameter int CLK_DELAY_STEPS = pdc_pkg::CLK_DELAY_STEPS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [pdc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pdc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [pdc_pkg::DATA_W-1:0] reg_rdata_reg,
	input wire logic [NUM_CHAN-1:0] channel_clock_in,
	input wire logic sysref_in,
	output logic [NUM_CHAN-1:0] clock_output,
	output logic [NUM_SYSREF-1:0] sysref_output,
	output logic [NUM_SYSREF*pdc_pkg::FINE_W-1:0] sysref_fine_delay_reg,
	output logic [NUM_SYSREF-1:0] sysref_leads_clock_reg,
	output logic [pdc_pkg::DAC_W-1:0] sysref_delay_unit_reg,
	output logic [pdc_pkg::MULT_W-1:0] oscillator_output_divider_reg,
	output logic calibration_oscillator_on,
	output logic irq
);
	import pdc_pkg::*;

	// --------------------------------------------------------------------
	// Elaboration checks
	// --------------------------------------------------------------------
	initial begin
		if (NUM_CHAN < 1 || NUM_CHAN > 8) begin
			$error("pdc_top: NUM_CHAN must lie in 1..8");
		end
		if (NUM_SYSREF < 1 || NUM_SYSREF > 8) begin
			$error("pdc_top: NUM_SYSREF must lie in 1..8");
		end
		if (CLK_DELAY_STEPS != (1 << CLK_DELAY_W)) begin
			$error("pdc_top: CLK_DELAY_STEPS must match the delay field width");
		end
	end

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	// Address match for a register array starting at base, one word each.
	function automatic logic arr_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base, input int idx);
		arr_hit = (addr == ADDR_W'(base + ADDR_W'(idx * 4)));
	endfunction

	// Multiplier code 0..3 stands for numeric multiplier 1..4.
	function automatic logic [2:0] mult_value(input logic [MULT_W-1:0] code);
		mult_value = {1'b0, code} + 3'h1;
	endfunction

	// --------------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------------
	logic calibration_start_bit_reg;
	logic [MULT_W-1:0] delay_unit_multiplier_reg;
	logic [DIV_W-1:0] reference_predivider_reg;
	logic [DIV_W-1:0] feedback_divider_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic [CLK_DELAY_W-1:0] clk_delay_reg [NUM_CHAN];
	logic [SYSREF_DELAY_W-1:0] sysref_delay_reg [NUM_SYSREF];
	logic cal_valid_reg;

	wire wr_ctrl = reg_write && (reg_addr == OFS_CTRL);
	wire wr_prediv = reg_write && (reg_addr == OFS_PREDIV);
	wire wr_fbdiv = reg_write && (reg_addr == OFS_FBDIV);
	wire wr_irq_status = reg_write && (reg_addr == OFS_IRQ_STATUS);
	wire wr_irq_mask = reg_write && (reg_addr == OFS_IRQ_MASK);

	// --------------------------------------------------------------------
	// Calibration control
	// --------------------------------------------------------------------
	logic cal_busy;
	logic cal_done;
	logic [DAC_W-1:0] cal_code;

	// A start request is taken only while no calibration runs; the start
	// bit then stays high until the engine reports completion.
	wire start_req = wr_ctrl && reg_wdata[CTRL_START_BIT] && !calibration_start_bit_reg;
	wire cal_limit = (cal_code == DAC_MIN) || (cal_code == DAC_MAX);
	wire [IRQ_W-1:0] irq_events = {cal_done && cal_limit, cal_done};

	pdc_cal_engine u_cal (
		.clk(clk),
		.rst(rst),
		.start(start_req),
		.prediv(reference_predivider_reg),
		.fbdiv(feedback_divider_reg),
		.mult(delay_unit_multiplier_reg),
		.busy(cal_busy),
		.done(cal_done),
		.code_reg(cal_code)
	);

	// Oscillator and its three dividers are powered only during a run.
	assign calibration_oscillator_on = cal_busy;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			calibration_start_bit_reg <= 1'b0;
		end else if (cal_done) begin
			calibration_start_bit_reg <= 1'b0;
		end else if (start_req) begin
			calibration_start_bit_reg <= 1'b1;
		end
	end

	// The multiplier also selects the oscillator output divider.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			delay_unit_multiplier_reg <= MULT_RESET;
			oscillator_output_divider_reg <= MULT_RESET;
		end else if (wr_ctrl && !calibration_start_bit_reg) begin
			delay_unit_multiplier_reg <= reg_wdata[CTRL_MULT_LSB +: MULT_W];
			oscillator_output_divider_reg <= reg_wdata[CTRL_MULT_LSB +: MULT_W];
		end
	end

	// Divider settings are frozen during a run so the engine sees one setup.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reference_predivider_reg <= PREDIV_RESET;
			feedback_divider_reg <= FBDIV_RESET;
		end else begin
			if (wr_prediv && !calibration_start_bit_reg) begin
				reference_predivider_reg <= reg_wdata[DIV_W-1:0];
			end
			if (wr_fbdiv && !calibration_start_bit_reg) begin
				feedback_divider_reg <= reg_wdata[DIV_W-1:0];
			end
		end
	end

	// --------------------------------------------------------------------
	// Latched delay unit
	// --------------------------------------------------------------------
	// Only the power-on reset discards the result; nothing the software
	// writes touches it outside a completed run.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sysref_delay_unit_reg <= '0;
			cal_valid_reg <= 1'b0;
		end else if (cal_done) begin
			sysref_delay_unit_reg <= cal_code;
			cal_valid_reg <= 1'b1;
		end
	end

	// --------------------------------------------------------------------
	// Interrupts
	// --------------------------------------------------------------------
	// A new event in the cycle of a write-one-to-clear keeps its bit set.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg &
				~(wr_irq_status ? reg_wdata[IRQ_W-1:0] : '0)) | irq_events;
			if (wr_irq_mask) begin
				irq_mask_reg <= reg_wdata[IRQ_W-1:0];
			end
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// --------------------------------------------------------------------
	// Clock channel delay
	// --------------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
			wire wr_this = reg_write && arr_hit(reg_addr, OFS_CLK_DELAY, gc);
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					clk_delay_reg[gc] <= '0;
				end else if (wr_this) begin
					clk_delay_reg[gc] <= reg_wdata[CLK_DELAY_W-1:0];
				end
			end
			// One step equals one input clock period, whatever the rate.
			pdc_delay_line #(
				.DEPTH(CLK_DELAY_STEPS),
				.SEL_W(CLK_DELAY_W)
			) u_line (
				.clk(clk),
				.rst(rst),
				.din(channel_clock_in[gc]),
				.sel(clk_delay_reg[gc]),
				.dout_reg(clock_output[gc])
			);
		end
	endgenerate

	// --------------------------------------------------------------------
	// SYSREF output delay
	// --------------------------------------------------------------------
	// The fine delay is expressed in eighths of the oscillator period;
	// the analog stage turns this code into time with the latched unit.
	wire [2:0] mult_num = mult_value(delay_unit_multiplier_reg);

	genvar gs;
	generate
		for (gs = 0; gs < NUM_SYSREF; gs++) begin : g_ref
			wire wr_this = reg_write && arr_hit(reg_addr, OFS_SYSREF_DELAY, gs);
			wire [FINE_W-1:0] fine = FINE_W'(sysref_delay_reg[gs]) * FINE_W'(mult_num);
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sysref_delay_reg[gs] <= '0;
					sysref_output[gs] <= 1'b0;
					sysref_fine_delay_reg[gs*FINE_W +: FINE_W] <= '0;
					sysref_leads_clock_reg[gs] <= 1'b0;
				end else begin
					if (wr_this) begin
						sysref_delay_reg[gs] <= reg_wdata[SYSREF_DELAY_W-1:0];
					end
					sysref_output[gs] <= sysref_in;
					sysref_fine_delay_reg[gs*FINE_W +: FINE_W] <= fine;
					sysref_leads_clock_reg[gs] <= (sysref_delay_reg[gs] <= SYSREF_LEAD_MAX);
				end
			end
		end
	endgenerate

	// --------------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			OFS_CTRL: begin
				rd_mux[CTRL_START_BIT] = calibration_start_bit_reg;
				rd_mux[CTRL_MULT_LSB +: MULT_W] = delay_unit_multiplier_reg;
			end
			OFS_PREDIV: rd_mux[DIV_W-1:0] = reference_predivider_reg;
			OFS_FBDIV: rd_mux[DIV_W-1:0] = feedback_divider_reg;
			OFS_RESULT: begin
				rd_mux[DAC_W-1:0] = sysref_delay_unit_reg;
				rd_mux[RESULT_VALID_BIT] = cal_valid_reg;
				rd_mux[RESULT_BUSY_BIT] = cal_busy;
				rd_mux[RESULT_OSC_BIT] = calibration_oscillator_on;
			end
			OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_reg;
			OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_reg;
			default: begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					if (arr_hit(reg_addr, OFS_CLK_DELAY, i)) begin
						rd_mux[CLK_DELAY_W-1:0] = clk_delay_reg[i];
					end
				end
				for (int i = 0; i < NUM_SYSREF; i++) begin
					if (arr_hit(reg_addr, OFS_SYSREF_DELAY, i)) begin
						rd_mux[SYSREF_DELAY_W-1:0] = sysref_delay_reg[i];
					end
				end
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe; zero otherwise.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata_reg <= '0;
		end else begin
			reg_rdata_reg <= reg_read ? rd_mux : '0;
		end
	end
endmodule
`default_nettype wire

// ---- verification/pdc_top_asserts.sv ----
`default_nettype none
module pdc_top_asserts
	import pdc_pkg::*;
#(
	parameter int NUM_CHAN = pdc_pkg::NUM_CHAN,
	parameter int NUM_SYSREF = pdc_pkg::NUM_SYSREF,
	parameter int CLK_DELAY_STEPS = pdc_pkg::CLK_DELAY_STEPS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [pdc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pdc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [pdc_pkg::DATA_W-1:0] reg_rdata_reg,
	input wire logic [NUM_CHAN-1:0] channel_clock_in,
	input wire logic sysref_in,
	input wire logic [NUM_CHAN-1:0] clock_output,
	input wire logic [NUM_SYSREF-1:0] sysref_output,
	input wire logic [NUM_SYSREF*pdc_pkg::FINE_W-1:0] sysref_fine_delay_reg,
	input wire logic [NUM_SYSREF-1:0] sysref_leads_clock_reg,
	input wire logic [pdc_pkg::DAC_W-1:0] sysref_delay_unit_reg,
	input wire logic [pdc_pkg::MULT_W-1:0] oscillator_output_divider_reg,
	input wire logic calibration_oscillator_on
);
	localparam int CAL_MAX = 15 * 256 + 2;
	logic [CLK_DELAY_STEPS:0] hist_reg;
	logic [CLK_DELAY_W-1:0] set0_reg;
	logic [1:0] settle_reg;
	logic [11:0] osc_cnt_reg;
	logic ctrl_wr;
	logic clk0_wr;
	logic sref0_wr;
	logic [MULT_W-1:0] wmult;
	logic [SYSREF_DELAY_W-1:0] wd3;
	logic [FINE_W-1:0] fine0_exp;
	assign ctrl_wr = reg_write && reg_addr == OFS_CTRL;
	assign clk0_wr = reg_write && reg_addr == OFS_CLK_DELAY;
	assign sref0_wr = reg_write && reg_addr == OFS_SYSREF_DELAY;
	assign wmult = reg_wdata[CTRL_MULT_LSB+:MULT_W];
	assign wd3 = reg_wdata[SYSREF_DELAY_W-1:0];
	assign fine0_exp = wd3 * ({1'b0, oscillator_output_divider_reg} + 3'h1);
	// The history is only trusted a few cycles after a delay write has settled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hist_reg <= '0;
			set0_reg <= '0;
			settle_reg <= '0;
			osc_cnt_reg <= '0;
		end else begin
			hist_reg <= {hist_reg[CLK_DELAY_STEPS-1:0], channel_clock_in[0]};
			if (clk0_wr) begin
				set0_reg <= reg_wdata[CLK_DELAY_W-1:0];
				settle_reg <= 2'h3;
			end else if (settle_reg != 2'h0) begin
				settle_reg <= settle_reg - 2'h1;
			end
			osc_cnt_reg <= calibration_oscillator_on ? osc_cnt_reg + 12'h001 : 12'h000;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_rdata_idle;
		!$past(reg_read) |-> reg_rdata_reg == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_sysref_pass;
		sysref_output == {NUM_SYSREF{$past(sysref_in)}};
	endproperty
	a_sysref_pass: assert property (p_sysref_pass) else $error("sysref path wrong");
	property p_div_follow;
		ctrl_wr && !calibration_oscillator_on |=> oscillator_output_divider_reg == $past(wmult);
	endproperty
	a_div_follow: assert property (p_div_follow) else $error("divider not loaded");
	property p_div_hold;
		calibration_oscillator_on |=> $stable(oscillator_output_divider_reg);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divider moved in run");
	property p_cal_start;
		ctrl_wr && reg_wdata[CTRL_START_BIT] && !calibration_oscillator_on |=> calibration_oscillator_on;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
	property p_cal_bound;
		osc_cnt_reg <= CAL_MAX;
	endproperty
	a_cal_bound: assert property (p_cal_bound) else $error("calibration too long");
	property p_unit_latch;
		$changed(sysref_delay_unit_reg) |-> $fell(calibration_oscillator_on);
	endproperty
	a_unit_latch: assert property (p_unit_latch) else $error("unit changed outside end");
	property p_leads;
		sref0_wr |-> ##2 sysref_leads_clock_reg[0] == ($past(wd3, 2) <= SYSREF_LEAD_MAX);
	endproperty
	a_leads: assert property (p_leads) else $error("lead flag wrong");
	property p_fine;
		sref0_wr |-> ##2 sysref_fine_delay_reg[FINE_W-1:0] == $past(fine0_exp, 2);
	endproperty
	a_fine: assert property (p_fine) else $error("fine delay wrong");
	property p_clk_delay;
		settle_reg == 2'h0 |-> clock_output[0] == hist_reg[9'(set0_reg) + 9'h001];
	endproperty
	a_clk_delay: assert property (p_clk_delay) else $error("clock delay wrong");
endmodule
bind pdc_top pdc_top_asserts #(
	.NUM_CHAN(NUM_CHAN),
	.NUM_SYSREF(NUM_SYSREF),
	.CLK_DELAY_STEPS(CLK_DELAY_STEPS)
) u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata_reg,
	.channel_clock_in, .sysref_in, .clock_output, .sysref_output, .sysref_fine_delay_reg,
	.sysref_leads_clock_reg, .sysref_delay_unit_reg, .oscillator_output_divider_reg,
	.calibration_oscillator_on);
`default_nettype wire

// ---- verification/pdc_clkgen_model.sv ----
`default_nettype none
module pdc_clkgen_model #(
	parameter int NUM_CHAN = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	output logic [NUM_CHAN-1:0] channel_clock_in,
	output logic sysref_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt_reg;
	// Two SYSREF rates let the bench show the delay paths ignore frequency.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			channel_clock_in <= '0;
			sysref_in <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
			channel_clock_in <= NUM_CHAN'($urandom);
			sysref_in <= slow ? cnt_reg == 6'h00 : cnt_reg[1];
		end
	end
endmodule
`default_nettype wire

// ---- verification/phase_delay_and_delay_calibration_bench.sv ----
`default_nettype none
module phase_delay_and_delay_calibration_bench import pdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [DATA_W-1:0] exp; logic [DATA_W-1:0] mask; string name;} pdc_note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic slow = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [DATA_W-1:0] reg_rdata_reg;
	logic [NUM_CHAN-1:0] channel_clock_in;
	logic sysref_in;
	logic [NUM_CHAN-1:0] clock_output;
	logic [NUM_SYSREF-1:0] sysref_output;
	logic [NUM_SYSREF*FINE_W-1:0] sysref_fine_delay_reg;
	logic [NUM_SYSREF-1:0] sysref_leads_clock_reg;
	logic [DAC_W-1:0] sysref_delay_unit_reg;
	logic [MULT_W-1:0] oscillator_output_divider_reg;
	logic calibration_oscillator_on;
	logic irq;
	logic rd_pend = 1'b0;
	logic [NUM_CHAN-1:0] hist [0:259];
	logic [7:0] cd [NUM_CHAN];
	logic [2:0] sd [NUM_SYSREF];
	pdc_note_t notes[$];
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	pdc_top dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata_reg,
		.channel_clock_in, .sysref_in, .clock_output, .sysref_output, .sysref_fine_delay_reg,
		.sysref_leads_clock_reg, .sysref_delay_unit_reg, .oscillator_output_divider_reg,
		.calibration_oscillator_on, .irq);
	pdc_clkgen_model #(.NUM_CHAN(NUM_CHAN)) gen_u (.clk, .rst, .slow, .channel_clock_in,
		.sysref_in);
	always #12.5 clk = ~clk;
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
		input logic [DATA_W-1:0] m, input string nm);
		pdc_note_t n;
		n.exp = e & m;
		n.mask = m;
		n.name = nm;
		notes.push_back(n);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
	endtask
	task automatic calrun(input logic [7:0] p, input logic [7:0] f, input logic [1:0] m);
		int n;
		n = 0;
		wr(OFS_PREDIV, 32'(p));
		wr(OFS_FBDIV, 32'(f));
		wr(OFS_CTRL, {29'h0, m, 1'b1});
		fork
			begin
				@(negedge clk);
				while (calibration_oscillator_on && n < 5000) begin
					n++;
					@(negedge clk);
				end
			end
			begin
				wr(OFS_PREDIV, 32'h9);
				wr(OFS_CTRL, 32'h7);
			end
		join
		chk("cal_cycles", 32'(15 * (p + 1) + 1), 32'(n));
		chk("divider", 32'(m), 32'(oscillator_output_divider_reg));
		rd(OFS_PREDIV, 32'(p), 32'hFF, "prediv_held");
		rd(OFS_CTRL, {29'h0, m, 1'b0}, 32'h7, "ctrl_after");
		rd(OFS_RESULT, 32'h8000, 32'h38000, "result");
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_pend <= reg_read;
		for (int i = 259; i > 0; i--) begin
			hist[i] <= hist[i-1];
		end
		hist[0] <= channel_clock_in;
		if (cyc == 6000) begin
			errors++;
			conclude();
		end
	end
	always @(negedge clk) begin
		pdc_note_t n;
		if (rd_pend && notes.size() > 0) begin
			n = notes.pop_front();
			chk(n.name, n.exp, reg_rdata_reg & n.mask);
		end
	end
	initial begin
		void'($urandom(32'h2811));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_PREDIV, 32'(PREDIV_RESET), '1, "prediv_reset");
		rd(OFS_FBDIV, 32'(FBDIV_RESET), '1, "fbdiv_reset");
		rd(OFS_CTRL, '0, '1, "ctrl_reset");
		rd(OFS_RESULT, '0, '1, "result_reset");
		wr(8'hFC, '1);
		rd(8'hFC, '0, '1, "unmapped");
		@(negedge clk);
		chk("irq", '0, 32'(irq));
		$display("reset test done");
		for (int ch = 0; ch < NUM_CHAN; ch++) begin
			cd[ch] = ch == 0 ? 8'hFF : ch == 1 ? 8'h00 : 8'($urandom);
			wr(OFS_CLK_DELAY + 8'(4 * ch), 32'(cd[ch]));
		end
		for (int ch = 0; ch < NUM_CHAN; ch++) begin
			rd(OFS_CLK_DELAY + 8'(4 * ch), 32'(cd[ch]), 32'hFF, "clk_delay");
		end
		repeat (262) @(negedge clk);
		slow <= 1'b1;
		repeat (20) begin
			@(negedge clk);
			for (int ch = 0; ch < NUM_CHAN; ch++) begin
				chk("clock_output", 32'(hist[cd[ch] + 1][ch]), 32'(clock_output[ch]));
			end
		end
		$display("clock delay test done");
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'(m << 1));
			for (int r = 0; r < NUM_SYSREF; r++) begin
				sd[r] = 3'(r + m);
				wr(OFS_SYSREF_DELAY + 8'(4 * r), 32'(sd[r]));
			end
			repeat (3) @(negedge clk);
			for (int r = 0; r < NUM_SYSREF; r++) begin
				chk("fine", 32'(5'(sd[r] * (m + 1))), 32'(sysref_fine_delay_reg[r*FINE_W+:FINE_W]));
				chk("leads", 32'(sd[r] <= 3'h3), 32'(sysref_leads_clock_reg[r]));
			end
		end
		rd(OFS_SYSREF_DELAY + 8'h1C, 32'(sd[7]), 32'h7, "sysref_delay");
		$display("sysref delay test done");
		wr(OFS_IRQ_MASK, 32'h3);
		calrun(8'h02, 8'h03, 2'h1);
		@(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		// These dividers can never reach the target, so the code ends at its upper limit.
		rd(OFS_IRQ_STATUS, 32'h3, 32'h3, "status_done");
		wr(OFS_IRQ_STATUS, 32'h3);
		rd(OFS_IRQ_STATUS, '0, 32'h3, "status_clear");
		@(negedge clk);
		chk("irq", '0, 32'(irq));
		wr(OFS_IRQ_MASK, '0);
		calrun(8'h04, 8'h06, 2'h0);
		@(negedge clk);
		chk("irq", '0, 32'(irq));
		wr(OFS_IRQ_MASK, 32'h1);
		@(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		wr(OFS_IRQ_STATUS, 32'h1);
		@(negedge clk);
		chk("irq", '0, 32'(irq));
		$display("calibration test done");
		repeat (4) @(posedge clk);
		conclude();
	end
endmodule
`default_nettype wire
